// [src/rcss_defines.svh]
`ifndef RCSS_DEFINES_SVH
`define RCSS_DEFINES_SVH

// Clock period in ns
`define RCSS_CLK_PERIOD_NS  10
// Clock monitor delay when the power-up delay is zero, in us
`define RCSS_CMON_DELAY_US  100
// Clock monitor delay in cycles, rounded down (shortest time)
`define RCSS_CMON_CYCLES    ((`RCSS_CMON_DELAY_US * 1000) / `RCSS_CLK_PERIOD_NS)
// Default power-on delay, in cycles
`define RCSS_POR_CYCLES     200
// Default power-up timer delay, in cycles
`define RCSS_POWER_UP_DELAY_TIMER_CYCLES    6400
// Default oscillator settle count, in cycles
`define RCSS_OST_CYCLES     1024
// Counter width
`define RCSS_CNT_W          20
// Source select field width
`define RCSS_SRC_W          2
// Primary mode field width
`define RCSS_MODE_W         4
// Source select codes
`define RCSS_SRC_FRC        2'h0
`define RCSS_SRC_LOW_POWER_INTERNAL_RC_OSC       2'h1
`define RCSS_SRC_SEC        2'h2
`define RCSS_SRC_PRI        2'h3
// Primary mode codes: bit 2 groups crystal and PLL
`define RCSS_MODE_EC        4'h0
`define RCSS_MODE_EXTERNAL_RC_OSC     4'h1
`define RCSS_MODE_XTAL      4'h4
`define RCSS_MODE_XTAL_PLL  4'h5

`endif

// [src/rcss_pkg.sv]
package rcss_pkg;
  // Start-up sequencer states, one-hot
  typedef enum logic [4:0] {
    RCSS_HOLD   = 5'h01,
    RCSS_DELAY  = 5'h02,
    RCSS_OSCW   = 5'h04,
    RCSS_RUN    = 5'h08,
    RCSS_SLEEP  = 5'h10
  } rcss_state_t;

  // Selected clock source as seen by the sequencer
  typedef enum logic [1:0] {
    RCSS_CK_FAST = 2'h0,
    RCSS_CK_LOWP = 2'h1,
    RCSS_CK_SEC  = 2'h2,
    RCSS_CK_PRI  = 2'h3
  } rcss_clk_t;
endpackage

// [src/rcss_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defines.svh"
// Shared down-counter carrier between sequencer and timer
interface rcss_timer_if;
  logic                   load;   // Load count
  logic [`RCSS_CNT_W-1:0] count;  // Count to load
  logic                   done;   // Count expired
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface
`default_nettype wire

// [src/rcss_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defines.svh"
// Reloadable down counter; done is high while the count sits at zero and load is low
module rcss_timer (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Control
  rcss_timer_if.timer    tif
);
  logic [`RCSS_CNT_W-1:0] cnt_r;  // Remaining cycles
  logic [`RCSS_CNT_W-1:0] cnt_nxt;

  // Load wins, else count down to zero
  assign cnt_nxt  = tif.load ? tif.count :
                    (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  assign tif.done = (cnt_r == '0) && !tif.load;

  // Counter register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// [src/rcss_seq.sv]
// How it works
// RULE_01: Reset takes clock source from configuration
// RULE_02: Monitor failure traps, falls back to fast RC
// RULE_03: No monitor, no power-up timer: fast exit
// RULE_04: RC and external clocks usable without wait
// RULE_05: Without monitor, core frozen until clock runs
// RULE_06: Brown-out reselects source from configuration fields
// RULE_07: Crystal brown-out starts settle timer, gates clock
// RULE_08: PLL use holds clock until lock
// RULE_09: Power-on and power-up delays run in parallel
// RULE_10: Zero power-up delay with crystal adds 100us
// RULE_11: Brown-out sets sticky status flag
// RULE_12: Brown-out detection active in Sleep, Idle
// RULE_13: Sleep exits on reset, watchdog, interrupt
// RULE_14: Idle keeps sources running, stops core clock
// RULE_15: Settle timer holds reset until crystal stable
// RULE_16: Power-up delay applies on power-up only
// RULE_17: Watchdog enabled by fuse or software, own RC
// RULE_18: Any reset request restarts whole sequence
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defines.svh"
module rcss_seq #(
  parameter int unsigned POR_CYCLES  = `RCSS_POR_CYCLES,  // Power-on delay
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RCSS_POWER_UP_DELAY_TIMER_CYCLES, // Power-up timer delay
  parameter int unsigned OST_CYCLES  = `RCSS_OST_CYCLES   // Oscillator settle
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Reset requests
  input  wire logic                    por_req,
  input  wire logic                    bor_req,
  input  wire logic                    ext_reset_req,
  input  wire logic                    bor_enable_cfg,
  // Configuration
  input  wire logic [`RCSS_SRC_W-1:0]  osc_source_select_cfg,
  input  wire logic [`RCSS_MODE_W-1:0] primary_osc_mode_cfg,
  input  wire logic                    fail_safe_clock_monitor_en,
  input  wire logic                    power_up_delay_timer_en,
  input  wire logic                    wdt_fuse_en,
  // Oscillator status
  input  wire logic                    osc_running,
  input  wire logic                    pll_locked,
  // Software controls
  input  wire logic                    sw_clk_switch,
  input  wire logic [`RCSS_SRC_W-1:0]  sw_clk_source,
  input  wire logic                    wdt_sw_en,
  input  wire logic                    bor_flag_clr,
  input  wire logic                    sleep_req,
  input  wire logic                    idle_req,
  // Wake sources
  input  wire logic                    wdt_wake,
  input  wire logic                    irq_wake,
  // Outputs
  output logic                         core_reset,
  output logic                         sys_clk_gate,
  output logic                         core_clk_gate,
  output logic                         osc_enable,
  output logic [`RCSS_SRC_W-1:0]       clk_source_sel,
  output logic                         clock_fail_trap,
  output logic                         brown_out_flag,
  output logic                         pll_lock_status,
  output logic                         wdt_enable,
  output logic                         wdt_osc_enable,
  output logic                         in_sleep,
  output logic                         in_idle
);
  // Timers: power-on/power-up delay and oscillator settle
  rcss_timer_if dly_if ();
  rcss_timer_if ost_if ();
  rcss_timer u_dly (.clk(clk), .rst(rst), .tif(dly_if));
  rcss_timer u_ost (.clk(clk), .rst(rst), .tif(ost_if));

  rcss_pkg::rcss_state_t       st_r, st_nxt;   // Sequencer state
  logic [`RCSS_SRC_W-1:0]      src_r, src_nxt; // Selected source
  logic                        trap_r;         // Clock failure trap
  logic                        bor_r;          // Brown-out status
  logic                        idle_r;         // Idle mode
  logic                        sysck_r;        // System clock gate
  logic                        lock_r;         // Lock status mirror
  logic                        wdt_r;          // Watchdog enable
  logic                        pwrup_r;        // Last reset was power-up

  // Returns true for crystal primary modes
  function automatic logic is_xtal(input logic [`RCSS_SRC_W-1:0] s,
                                   input logic [`RCSS_MODE_W-1:0] m);
    is_xtal = (s == `RCSS_SRC_PRI) &&
              ((m == `RCSS_MODE_XTAL) || (m == `RCSS_MODE_XTAL_PLL));
  endfunction

  // Returns true when PLL is in use
  function automatic logic uses_pll(input logic [`RCSS_SRC_W-1:0] s,
                                    input logic [`RCSS_MODE_W-1:0] m);
    uses_pll = (s == `RCSS_SRC_PRI) && (m == `RCSS_MODE_XTAL_PLL);
  endfunction

  // Brown-out only counts when detection is enabled, also in Sleep/Idle
  wire bor_hit   = bor_req && bor_enable_cfg;                   // [RULE_12]
  wire any_reset = por_req || bor_hit || ext_reset_req;         // [RULE_18]
  wire xtal_sel  = is_xtal(src_r, primary_osc_mode_cfg);
  wire pll_sel   = uses_pll(src_r, primary_osc_mode_cfg);
  // Clock is ready when running, settled and locked as needed
  wire clk_ready = osc_running && (!xtal_sel || ost_if.done)    // [RULE_15]
                   && (!pll_sel || pll_locked);                 // [RULE_08]
  // Delay timer loads in the request's own cycle, so read the request
  // itself there; the registered source and power-up copy lag a cycle
  wire pwrup_now = any_reset ? por_req : pwrup_r;
  wire cfg_xtal  = is_xtal(osc_source_select_cfg, primary_osc_mode_cfg);
  // Power-up delay count: only on power-up and when enabled
  wire use_power_up_delay_timer  = pwrup_now && power_up_delay_timer_en;        // [RULE_16]
  // Fast exit: no monitor and no power-up timer
  wire fast_exit = !fail_safe_clock_monitor_en && !power_up_delay_timer_en; // [RULE_03]
  // Longer of the two parallel delays, or power-on plus the monitor delay
  wire [`RCSS_CNT_W-1:0] dly_cnt =
      fast_exit ? `RCSS_CNT_W'(1) :
      use_power_up_delay_timer  ? ((POWER_UP_DELAY_TIMER_CYCLES > POR_CYCLES) ? `RCSS_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES)
                                              : `RCSS_CNT_W'(POR_CYCLES)) :  // [RULE_09]
      cfg_xtal  ? `RCSS_CNT_W'(POR_CYCLES + `RCSS_CMON_CYCLES) :             // [RULE_10]
                  `RCSS_CNT_W'(POR_CYCLES);
  wire wake      = wdt_wake || irq_wake;                        // [RULE_13]

  // Timer loads: delay restarts on any reset request, settle timer only with a crystal configured
  assign dly_if.load  = any_reset;
  assign dly_if.count = dly_cnt;
  assign ost_if.load  = any_reset && cfg_xtal;                  // [RULE_07]
  assign ost_if.count = `RCSS_CNT_W'(OST_CYCLES);

  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      rcss_pkg::RCSS_HOLD:  st_nxt = rcss_pkg::RCSS_DELAY;
      rcss_pkg::RCSS_DELAY: begin
        if (dly_if.done) begin
          st_nxt = rcss_pkg::RCSS_OSCW;
        end
      end
      rcss_pkg::RCSS_OSCW: begin
        // Monitor traps instead of waiting; else freeze till clock
        if (fail_safe_clock_monitor_en || clk_ready) begin       // [RULE_05]
          st_nxt = rcss_pkg::RCSS_RUN;
        end
      end
      rcss_pkg::RCSS_RUN: begin
        if (sleep_req) begin
          st_nxt = rcss_pkg::RCSS_SLEEP;
        end
      end
      rcss_pkg::RCSS_SLEEP: begin
        if (wake) begin
          st_nxt = rcss_pkg::RCSS_RUN;                           // [RULE_13]
        end
      end
      default: st_nxt = rcss_pkg::RCSS_HOLD;
    endcase
    if (any_reset) begin
      st_nxt = rcss_pkg::RCSS_HOLD;                              // [RULE_18]
    end
  end

  // Trap when monitor sees a bad clock at end of the delays
  wire trap_nxt_set = fail_safe_clock_monitor_en && !clk_ready &&
                      (st_r == rcss_pkg::RCSS_OSCW);              // [RULE_02]

  // Source selection: configuration on reset, software afterwards
  assign src_nxt = any_reset ? osc_source_select_cfg :            // [RULE_01] [RULE_06]
                   (trap_nxt_set ? `RCSS_SRC_FRC :                // [RULE_02]
                   ((sw_clk_switch && st_r == rcss_pkg::RCSS_RUN) ? sw_clk_source : src_r));

  // Sequencer state and source
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r  <= rcss_pkg::RCSS_HOLD;
      src_r <= `RCSS_SRC_FRC;
    end else begin
      st_r  <= st_nxt;
      src_r <= src_nxt;
    end
  end

  // Trap flag, sticky until the next reset
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      trap_r <= 1'b0;
    end else if (trap_nxt_set) begin
      trap_r <= 1'b1;
    end
  end

  // Brown-out flag: set wins over software clear
  always_ff @(posedge clk) begin
    if (rst) begin
      bor_r <= 1'b0;
    end else if (bor_hit) begin
      bor_r <= 1'b1;                                             // [RULE_11]
    end else if (bor_flag_clr) begin
      bor_r <= 1'b0;
    end
  end

  // Remember whether the latest reset was a power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      pwrup_r <= 1'b1;
    end else if (any_reset) begin
      pwrup_r <= por_req;                                        // [RULE_16]
    end
  end

  // Idle mode: core clock stopped, sources stay up
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      idle_r <= 1'b0;
    end else if (idle_r && wake) begin
      idle_r <= 1'b0;
    end else if (idle_req && st_r == rcss_pkg::RCSS_RUN) begin
      idle_r <= 1'b1;                                            // [RULE_14]
    end
  end

  // System clock gate: off until ready, or forced on after trap to fast RC
  // Internal RC and external clocks need no settle wait
  always_ff @(posedge clk) begin
    if (rst || any_reset) begin
      sysck_r <= 1'b0;                                           // [RULE_07]
    end else if (st_r == rcss_pkg::RCSS_SLEEP) begin
      sysck_r <= 1'b0;
    end else begin
      sysck_r <= (src_r == `RCSS_SRC_FRC) || trap_r || clk_ready; // [RULE_04] [RULE_08]
    end
  end

  // Lock mirror and watchdog enable
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_r <= 1'b0;
      wdt_r  <= 1'b0;
    end else begin
      lock_r <= pll_locked;
      wdt_r  <= wdt_fuse_en || wdt_sw_en;                        // [RULE_17]
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reset     <= 1'b1;
      core_clk_gate  <= 1'b0;
      osc_enable     <= 1'b0;
      clk_source_sel <= `RCSS_SRC_FRC;
      in_sleep       <= 1'b0;
      in_idle        <= 1'b0;
      wdt_osc_enable <= 1'b0;
    end else begin
      core_reset     <= (st_nxt != rcss_pkg::RCSS_RUN) &&
                        (st_nxt != rcss_pkg::RCSS_SLEEP);        // [RULE_09]
      core_clk_gate  <= (st_nxt == rcss_pkg::RCSS_RUN) && !idle_r; // [RULE_14]
      osc_enable     <= (st_nxt != rcss_pkg::RCSS_SLEEP);        // [RULE_14]
      clk_source_sel <= src_r;
      in_sleep       <= (st_nxt == rcss_pkg::RCSS_SLEEP);
      in_idle        <= idle_r;
      wdt_osc_enable <= wdt_fuse_en || wdt_sw_en;                // [RULE_17]
    end
  end

  assign sys_clk_gate    = sysck_r;
  assign clock_fail_trap = trap_r;
  assign brown_out_flag  = bor_r;
  assign pll_lock_status = lock_r;
  assign wdt_enable      = wdt_r;

  // Assertions
  property p_bor_flag;
    @(posedge clk) disable iff (rst) bor_hit |=> brown_out_flag;
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out flag not set"); // [RULE_11]

  property p_reset_restart;
    @(posedge clk) disable iff (rst) any_reset |=> core_reset;
  endproperty
  a_reset_restart: assert property (p_reset_restart) else $error("reset not asserted"); // [RULE_18]

  property p_cfg_source;
    @(posedge clk) disable iff (rst)
      any_reset |=> src_r == $past(osc_source_select_cfg);
  endproperty
  a_cfg_source: assert property (p_cfg_source) else $error("source not from config"); // [RULE_01]

  property p_trap_frc;
    @(posedge clk) disable iff (rst)
      trap_nxt_set && !any_reset |=> clock_fail_trap && src_r == `RCSS_SRC_FRC;
  endproperty
  a_trap_frc: assert property (p_trap_frc) else $error("trap without fallback"); // [RULE_02]

  property p_pll_hold;
    @(posedge clk) disable iff (rst)
      pll_sel && !pll_locked && !trap_r && src_r != `RCSS_SRC_FRC && !any_reset
      |=> !sys_clk_gate;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("clock ran before lock"); // [RULE_08]

  property p_ost_hold;
    @(posedge clk) disable iff (rst)
      xtal_sel && !ost_if.done && !trap_r && !any_reset |=> !sys_clk_gate;
  endproperty
  a_ost_hold: assert property (p_ost_hold) else $error("clock ran before settle"); // [RULE_07]

  property p_freeze;
    @(posedge clk) disable iff (rst)
      st_r == rcss_pkg::RCSS_OSCW && !fail_safe_clock_monitor_en && !clk_ready
      && !any_reset |=> core_reset;
  endproperty
  a_freeze: assert property (p_freeze) else $error("core left frozen state"); // [RULE_05]

  property p_wake;
    @(posedge clk) disable iff (rst)
      st_r == rcss_pkg::RCSS_SLEEP && wake && !any_reset |=> !in_sleep;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep"); // [RULE_13]

  property p_idle;
    @(posedge clk) disable iff (rst) in_idle |-> !core_clk_gate && osc_enable;
  endproperty
  a_idle: assert property (p_idle) else $error("idle gating wrong"); // [RULE_14]

  property p_wdt;
    @(posedge clk) disable iff (rst) wdt_fuse_en |=> wdt_enable && wdt_osc_enable;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog not enabled"); // [RULE_17]
endmodule
`default_nettype wire

// [tb/rcss_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the processor core behind the sequencer
module rcss_core_model (
  // Clock
  input  wire logic        clk,
  // From the sequencer
  input  wire logic        core_reset,
  input  wire logic        core_clk_gate,
  // Fetch position, zero is the reset vector
  output logic [15:0]      pc
);
  // Parked at the vector while held; steps only when its clock is let through
  always_ff @(posedge clk) begin
    if (core_reset) begin
      pc <= 16'h0000;
    end else if (core_clk_gate) begin
      pc <= pc + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [tb/reset_clock_startup_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rcss_defines.svh"
module reset_clock_startup_sequencer_tb;
  localparam int P  = 4;                 // Power-on delay, kept short
  localparam int W  = 8;                 // Power-up timer delay, kept short
  localparam int O  = 4;                 // Oscillator settle count
  localparam int CM = `RCSS_CMON_CYCLES; // Monitor delay, not shortened
  // Pulse request codes
  localparam int K_POR = 0, K_BOR = 1, K_EXT = 2, K_SLP = 3, K_IDL = 4;
  localparam int K_IRQ = 5, K_WDT = 6, K_SW = 7, K_CLR = 8;
  // Inputs
  logic clk, rst, por_req, bor_req, ext_reset_req, bor_enable_cfg;
  logic [`RCSS_SRC_W-1:0]  osc_source_select_cfg, sw_clk_source;
  logic [`RCSS_MODE_W-1:0] primary_osc_mode_cfg;
  logic fail_safe_clock_monitor_en, power_up_delay_timer_en, wdt_fuse_en;
  logic osc_running, pll_locked, sw_clk_switch, wdt_sw_en, bor_flag_clr;
  logic sleep_req, idle_req, wdt_wake, irq_wake;
  // Outputs
  logic core_reset, sys_clk_gate, core_clk_gate, osc_enable, clock_fail_trap;
  logic brown_out_flag, pll_lock_status, wdt_enable, wdt_osc_enable, in_sleep, in_idle;
  logic [`RCSS_SRC_W-1:0]  clk_source_sel;
  logic [15:0]             pc;   // Core fetch position
  logic [8:0]              pv;   // One-hot pulse request vector
  logic [15:0]             lf;   // Random state
  int                      n_tests, miscompares, n, m;

  // All one-cycle controls come from one vector, so only one is high at a time
  assign {bor_flag_clr, sw_clk_switch, wdt_wake, irq_wake, idle_req, sleep_req,
          ext_reset_req, bor_req, por_req} = pv;

  rcss_seq #(.POR_CYCLES(P), .POWER_UP_DELAY_TIMER_CYCLES(W), .OST_CYCLES(O)) dut_u (
    .clk, .rst, .por_req, .bor_req, .ext_reset_req, .bor_enable_cfg,
    .osc_source_select_cfg, .primary_osc_mode_cfg, .fail_safe_clock_monitor_en,
    .power_up_delay_timer_en, .wdt_fuse_en, .osc_running, .pll_locked,
    .sw_clk_switch, .sw_clk_source, .wdt_sw_en, .bor_flag_clr, .sleep_req,
    .idle_req, .wdt_wake, .irq_wake, .core_reset, .sys_clk_gate, .core_clk_gate,
    .osc_enable, .clk_source_sel, .clock_fail_trap, .brown_out_flag,
    .pll_lock_status, .wdt_enable, .wdt_osc_enable, .in_sleep, .in_idle);
  rcss_core_model core_u (.clk, .core_reset, .core_clk_gate, .pc);

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Random source, fixed start
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected hold from power-on, power-up timer and crystal choice
  function automatic int dly(input bit pu, input bit pw, input bit xt);
    if (pu && pw) return (P > W) ? P : W;
    // Crystal gets the monitor delay whenever no power-up delay applies
    if (xt && !(pu && pw)) return P + CM;
    return P;
  endfunction

  // Value comparison
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Cycle count comparison against a window
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Inputs only move on falling edges
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic pulse(input int k);
    pv = 9'h001 << k;
    cyc(1);
    pv = '0;
  endtask
  // Bounded wait for the core to be let go
  task automatic wrel(input int lim);
    n = 0;
    while (core_reset !== 1'b0 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rq(input int k, input int lim);
    pulse(k);
    wrel(lim);
  endtask
  task automatic cfg(input logic [1:0] s, input logic [3:0] md, input logic f, input logic pw);
    osc_source_select_cfg = s;
    primary_osc_mode_cfg = md;
    fail_safe_clock_monitor_en = f;
    power_up_delay_timer_en = pw;
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run is about 20k cycles; over twice that means a hang
  initial begin
    repeat (44000) @(posedge clk);
    miscompares++;
    $display("unexpected watchdog expected finish seen hang");
    wrap_up();
  end

  initial begin
    pv = '0;
    {rst, bor_enable_cfg, osc_running, pll_locked} = '1;
    {wdt_fuse_en, wdt_sw_en} = '0;
    cfg(2'h0, 4'h0, 1'b0, 1'b1);
    sw_clk_source = 2'h0;
    n_tests = 0;
    miscompares = 0;
    lf = 16'h85D4;
    cyc(6);
    rst = 1'b0;
    cyc(1);
    // Immediate sources: fast RC, low-power RC, external clock, external RC
    for (int i = 0; i < 4; i++) begin
      cfg(2'(i < 2 ? i : 3), 4'(i == 3), 1'b0, 1'b1);
      rq(K_POR, 100);
      m = n;
      chk_rng("power_up_release", dly(1, 1, 0), dly(1, 1, 0) + 5, n);
      chk("reset_source", osc_source_select_cfg, clk_source_sel);
      lf = lfsr(lf);
      sw_clk_source = {1'b0, lf[0]};
      pulse(K_SW);
      cyc(2);
      chk("sw_source", sw_clk_source, clk_source_sel);
      chk("core_runs", 1, pc !== 16'h0);
      rq(K_EXT, 100);
      chk_rng("ext_release", dly(0, 1, 0), m - 1, n);
    end
    $display("test power_up done");
    cfg(2'h0, 4'h0, 1'b0, 1'b0);
    rq(K_POR, 100);
    chk_rng("fast_exit", 0, P + 1, n);
    // Second request part way through must start over
    cfg(2'h0, 4'h0, 1'b0, 1'b1);
    pulse(K_POR);
    lf = lfsr(lf);
    cyc(2 + lf[1:0]);
    rq(K_POR, 100);
    chk_rng("restart", W, W + 5, n);
    $display("test fast_exit_restart done");
    // Monitor on, crystal dead at end of delays
    cfg(2'h3, 4'h4, 1'b1, 1'b1);
    osc_running = 1'b0;
    rq(K_POR, 100);
    cyc(2);
    chk_rng("trap_release", W, W + 5, n);
    chk("trap", 1, clock_fail_trap);
    chk("fallback", `RCSS_SRC_FRC, clk_source_sel);
    osc_running = 1'b1;
    cfg(2'h0, 4'h0, 1'b0, 1'b1);
    rq(K_EXT, 100);
    chk("trap_clear", 0, clock_fail_trap);
    // Brown-out with crystal still silent: core stays at the vector
    cfg(2'h3, 4'h4, 1'b0, 1'b1);
    osc_running = 1'b0;
    rq(K_BOR, P + CM + 8);
    chk_rng("bor_hold", P + CM + 8, P + CM + 8, n);
    chk("frozen", 1, core_reset);
    chk("vector", 0, pc);
    chk("bor_flag", 1, brown_out_flag);
    osc_running = 1'b1;
    wrel(40);
    chk_rng("settle", 0, O + 6, n);
    pulse(K_CLR);
    cyc(1);
    chk("bor_flag_clr", 0, brown_out_flag);
    // Monitor on, so the fast exit does not cut the monitor delay
    cfg(2'h3, 4'h4, 1'b1, 1'b0);
    rq(K_POR, 20000);
    chk_rng("xtal_zero_power_up_delay_timer", dly(1, 0, 1), dly(1, 0, 1) + O + 5, n);
    // Lock missing keeps the clock back
    cfg(2'h3, 4'h5, 1'b0, 1'b1);
    pll_locked = 1'b0;
    rq(K_POR, 40);
    chk("pll_hold", 1, core_reset);
    chk("pll_status", 0, pll_lock_status);
    pll_locked = 1'b1;
    wrel(40);
    chk_rng("pll_release", 0, O + 6, n);
    chk("pll_status", 1, pll_lock_status);
    $display("test oscillator_waits done");
    // Software moves the source, brown-out puts it back
    cfg(2'h1, 4'h0, 1'b0, 1'b1);
    rq(K_POR, 100);
    sw_clk_source = 2'h0;
    pulse(K_SW);
    cyc(2);
    chk("sw_to_fast", 0, clk_source_sel);
    rq(K_BOR, 100);
    chk("bor_reselect", 1, clk_source_sel);
    bor_enable_cfg = 1'b0;
    pulse(K_BOR);
    cyc(2);
    chk("bor_disabled", 0, core_reset);
    bor_enable_cfg = 1'b1;
    // Each wake source out of Sleep
    for (int w = 0; w < 4; w++) begin
      pulse(K_SLP);
      cyc(2);
      chk("sleep", 1, in_sleep);
      chk("sleep_osc", 0, osc_enable);
      pulse(w == 0 ? K_IRQ : w == 1 ? K_WDT : w == 2 ? K_EXT : K_BOR);
      chk("wake_reset", w > 1, core_reset);
      cyc(2);
      chk("wake", 0, in_sleep);
      wrel(100);
    end
    pulse(K_IDL);
    cyc(2);
    chk("idle", 1, in_idle);
    chk("idle_core_clk", 0, core_clk_gate);
    chk("idle_sys_clk", 1, sys_clk_gate);
    chk("idle_osc", 1, osc_enable);
    m = pc;
    cyc(3);
    chk("idle_pc", m[15:0], pc);
    rq(K_EXT, 100);
    chk("idle_exit", 0, in_idle);
    $display("test power_saving done");
    for (int i = 0; i < 4; i++) begin
      {wdt_fuse_en, wdt_sw_en} = 2'(i);
      cyc(2);
      chk("wdt_enable", i != 0, wdt_enable);
      chk("wdt_osc", i != 0, wdt_osc_enable);
    end
    $display("test watchdog done");
    wrap_up();
  end
endmodule
`default_nettype wire
